/* File: logic/cfs_core.sv */
/*
 * instruction sequencing core: four-phase instruction cycle, fetch/execute
 * overlap, program counter with addressable low byte, six-level return
 * stack with interrupt hold-off, and 8-bit alu with status flags.
 * assumes program memory answers within the T1 phase, data memory answers
 * a read by the end of T3 and writes on the T4 strobe, and a wishbone
 * classic master on the register port.
 */
// Notes on behaviour
// - clock splits into four phases; four phases make one instruction cycle.
// - pc increments and next instruction fetched in first phase; rest execute.
// - fetch of next instruction overlaps execution of current one.
// - pc-changing instructions take two instruction cycles.
// - pc advances by one per instruction unless a jump, call, return, interrupt entry or low-byte write loads.
// - jumps, calls, interrupt entry and reset load target into pc directly.
// - taken skip discards prefetched instruction and runs a dummy cycle.
// - only pc low byte is software addressable; high part four bits here.
// - writing pc low byte jumps within current 256-word page, dummy cycle.
// - stack holds pc values only; stack and pointer hidden from software.
// - call and interrupt entry push pc; returns pop it back.
// - reset sets stack pointer to top of stack.
// - stack full: interrupt flag kept, acknowledge held until a return.
// - call with full stack still runs; oldest saved entry is lost.
// - 8-bit alu; data moves via accumulator; result to chosen destination.
// - alu operations update carry, borrow and other status flags.
// - add, sub, carry forms, decimal adjust, logic, rotates, inc, dec.
// - jump, call, returns, skip zero/nonzero, inc/dec then skip on zero.
// - after reset pc is zero and execution starts there.
`timescale 1ns/1ps
module cfs_core
	import cfs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [11:0] prog_addr_o,
	input wire logic [15:0] prog_data_i,
	output cfs_dm_req_t dm_o,
	input wire logic [7:0] dm_rdata_i,
	input wire logic irq_i,
	output logic int_ack_o,
	output cfs_phase_t instruction_phases_o
);

	cfs_state_t st;
	cfs_state_t nx;

	cfs_op_t op;
	logic is_branch;
	logic is_call;
	logic dest_mem;
	logic [7:0] opnd;
	logic [7:0] add_b;
	logic add_ci;
	logic [8:0] sum9;
	logic [4:0] nib5;
	logic [11:0] stack_top;
	logic [5:0][11:0] stack_shift;
	logic redirect;
	logic [11:0] target;
	logic do_push;
	logic do_pop;
	logic [11:0] push_val;
	logic take_int;
	logic pcl_hit;
	logic bus_req;
	logic int_ok;
	logic wr_pcl;
	logic wr_ctrl;

	assign is_branch = st.ir[INS_BRANCH];
	assign is_call = st.ir[INS_CALL];
	assign op = is_branch ? OP_NOP : cfs_op_t'(st.ir[INS_OP_HI:INS_OP_LO]);
	assign dest_mem = st.ir[INS_DEST];
	assign pcl_hit = (st.ir[7:0] == DM_PCL_ADDR);
	assign opnd = pcl_hit ? st.fetch_pc[7:0] : dm_rdata_i;

	// an empty pop reuses the bottom entry instead of indexing past the array
	always_comb begin
		if (st.sp == SP_TOP) begin
			stack_top = st.stack[0];
		end else begin
			stack_top = st.stack[3'(st.sp - 3'h1)];
		end
	end

	// six levels, fixed by the package depth
	genvar gi;
	generate
		for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_shift
			if (gi == STACK_DEPTH - 1) begin : g_last
				assign stack_shift[gi] = push_val;
			end else begin : g_mid
				assign stack_shift[gi] = st.stack[gi + 1];
			end
		end
	endgenerate

	assign bus_req = wb_cyc_i & wb_stb_i & ~st.wb_ack;

	// a full stack withholds the acknowledge; the flag stays set
	assign int_ok = st.int_pend && st.int_en && (st.sp != SP_FULL);
	// a bus write to the low byte becomes a pending in-page jump
	assign wr_pcl = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == REG_PCL);
	assign wr_ctrl = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == REG_CTRL);

	always_comb begin
		nx = st;
		add_b = opnd;
		add_ci = 1'b0;
		sum9 = '0;
		nib5 = '0;
		redirect = 1'b0;
		target = st.pc;
		do_push = 1'b0;
		do_pop = 1'b0;
		push_val = st.fetch_pc;
		take_int = 1'b0;
		nx.int_ack = 1'b0;

		// adder operand selection shared by add/sub forms
		case (op)
			OP_ADC: add_ci = st.flg.c;
			OP_SUB: begin
				add_b = ~opnd;
				add_ci = 1'b1;
			end
			OP_SBC: begin
				add_b = ~opnd;
				add_ci = st.flg.c;
			end
			default: add_ci = 1'b0;
		endcase
		sum9 = {1'b0, st.acc} + {1'b0, add_b} + {8'h00, add_ci};
		nib5 = {1'b0, st.acc[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_ci};

		if (st.run) begin
			case (st.phase)
				PH_T1: begin
					// fetch and increment
					// prog_data_i must be settled by the edge that ends T1
					nx.fetch_q = prog_data_i;
					nx.fetch_pc = st.pc;
					nx.pc = st.pc + 12'h001;
					nx.phase = PH_T2;
				end
				PH_T2: nx.phase = PH_T3;
				PH_T3: begin
					nx.phase = PH_T4;
					nx.res = st.acc;
					nx.res_flg = st.flg;
					nx.res_acc = 1'b0;
					nx.res_mem = 1'b0;
					nx.skip = 1'b0;
					case (op)
						OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
							nx.res = sum9[7:0];
							nx.res_flg.c = sum9[8];
							nx.res_flg.ac = nib5[4];
							nx.res_flg.z = (sum9[7:0] == 8'h00);
							nx.res_flg.ov = (st.acc[7] == add_b[7]) &&
								(sum9[7] != st.acc[7]);
						end
						OP_DAA: begin
							nx.res = st.acc +
								((st.flg.ac || st.acc[3:0] > DAA_NIB_MAX) ?
								DAA_LO_ADJ : 8'h00) +
								((st.flg.c || st.acc > DAA_BYTE_MAX) ?
								DAA_HI_ADJ : 8'h00);
							nx.res_flg.c = st.flg.c || (st.acc > DAA_BYTE_MAX);
						end
						OP_AND: nx.res = st.acc & opnd;
						OP_OR: nx.res = st.acc | opnd;
						OP_XOR: nx.res = st.acc ^ opnd;
						OP_CPL: nx.res = ~opnd;
						OP_RR: nx.res = {opnd[0], opnd[7:1]};
						OP_RL: nx.res = {opnd[6:0], opnd[7]};
						OP_RRC: begin
							nx.res = {st.flg.c, opnd[7:1]};
							nx.res_flg.c = opnd[0];
						end
						OP_RLC: begin
							nx.res = {opnd[6:0], st.flg.c};
							nx.res_flg.c = opnd[7];
						end
						OP_INC, OP_SIZ: nx.res = opnd + 8'h01;
						OP_DEC, OP_SDZ: nx.res = opnd - 8'h01;
						OP_SZ, OP_SNZ, OP_LDA: nx.res = opnd;
						OP_LDI: nx.res = st.ir[7:0];
						default: nx.res = st.acc;
					endcase
					// zero flag for logic, plain inc/dec and lda; ldi leaves it alone
					case (op)
						OP_AND, OP_OR, OP_XOR, OP_CPL, OP_INC, OP_DEC, OP_LDA:
							nx.res_flg.z = (nx.res == 8'h00);
						default: nx.res_flg.z = nx.res_flg.z;
					endcase
					case (op)
						OP_SZ: nx.skip = (opnd == 8'h00);
						OP_SNZ: nx.skip = (opnd != 8'h00);
						OP_SIZ, OP_SDZ: nx.skip = (nx.res == 8'h00);
						default: nx.skip = 1'b0;
					endcase
					case (op)
						OP_NOP, OP_RET, OP_INTERRUPT_RETURN: begin
							nx.res_acc = 1'b0;
							nx.res_mem = 1'b0;
						end
						OP_STA: nx.res_mem = 1'b1;
						OP_LDA, OP_LDI, OP_DAA: nx.res_acc = 1'b1;
						OP_SZ, OP_SNZ: nx.res_acc = ~dest_mem;
						default: begin
							nx.res_mem = dest_mem;
							nx.res_acc = ~dest_mem;
						end
					endcase
				end
				PH_T4: begin
					nx.phase = PH_T1;
					if (st.ir_valid) begin
						if (st.res_acc) begin
							nx.acc = st.res;
						end
						nx.flg = st.res_flg;
						if (st.res_mem && pcl_hit) begin
							redirect = 1'b1;
							target = {st.fetch_pc[11:8], st.res};
						end
						if (st.skip) begin
							redirect = 1'b1;
							target = st.pc;
						end
						if (is_branch) begin
							redirect = 1'b1;
							target = st.ir[11:0];
							do_push = is_call;
						end
						if (op == OP_RET || op == OP_INTERRUPT_RETURN) begin
							redirect = 1'b1;
							target = stack_top;
							do_pop = 1'b1;
							if (op == OP_INTERRUPT_RETURN) begin
								nx.int_en = 1'b1;
							end
						end
					end
					// bus write of the low byte overrides any in-flight target
					if (st.pcl_pend) begin
						redirect = 1'b1;
						target = {st.fetch_pc[11:8], st.pcl_val};
						nx.pcl_pend = 1'b0;
					end
					if (!redirect && int_ok) begin
						take_int = 1'b1;
						redirect = 1'b1;
						target = INT_VECTOR;
						do_push = 1'b1;
						nx.int_en = 1'b0;
						nx.int_ack = 1'b1;
					end
					if (redirect) begin
						nx.pc = target;
					end
					nx.ir = st.fetch_q;
					// a redirect turns the word already fetched into a dummy cycle
					nx.ir_valid = ~redirect;
				end
				default: nx.phase = PH_T1;
			endcase
		end

		// stack reached only by push and pop
		if (do_push) begin
			if (st.sp == SP_FULL) begin
				nx.stack = stack_shift;
			end else begin
				nx.stack[st.sp] = push_val;
				nx.sp = st.sp + 3'h1;
			end
		end else if (do_pop && st.sp != SP_TOP) begin
			// an empty pop leaves the pointer at the top instead of wrapping
			nx.sp = st.sp - 3'h1;
		end

		// request flag: a new request in the ack cycle stays recorded
		nx.int_pend = (st.int_pend & ~take_int) | irq_i;

		// wishbone slave, one wait state
		// a low clock enable also stalls the answer, so masters wait for ack
		nx.wb_ack = bus_req;
		if (bus_req) begin
			nx.wb_dat = '0;
			if (wb_we_i) begin
				if (wr_pcl) begin
					nx.pcl_pend = 1'b1;
					nx.pcl_val = wb_dat_i[7:0];
				end
				if (wr_ctrl) begin
					nx.run = wb_dat_i[CTRL_RUN];
					nx.int_en = wb_dat_i[CTRL_IEN];
				end
			end else begin
				case (wb_adr_i)
					REG_PCL: nx.wb_dat[7:0] = st.fetch_pc[7:0];
					REG_CTRL: begin
						nx.wb_dat[CTRL_RUN] = st.run;
						nx.wb_dat[CTRL_IEN] = st.int_en;
					end
					REG_STAT: begin
						nx.wb_dat[STAT_ACC_LO +: 8] = st.acc;
						nx.wb_dat[STAT_FLG_LO +: 4] = st.flg;
						nx.wb_dat[STAT_PEND] = st.int_pend;
						nx.wb_dat[STAT_RUN] = st.run;
					end
					default: nx.wb_dat = '0;
				endcase
			end
		end
	end

	// state register, six-entry stack included
	// reset wins over the clock enable so a frozen core can still restart
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= cfs_reset_state();
		end else if (ce_i) begin
			st <= nx;
		end
	end

	assign wb_dat_o = st.wb_dat;
	// ack drops the cycle after it is given even if the master is slow
	assign wb_ack_o = st.wb_ack;
	assign prog_addr_o = st.pc;
	assign int_ack_o = st.int_ack;
	assign instruction_phases_o = st.phase;
	assign dm_o.addr = st.ir[7:0];
	assign dm_o.wdata = st.res;
	// pc low byte lives in the core, so data memory never sees that write
	// a frozen T4 under a low clock enable must not repeat the strobe
	assign dm_o.we = ce_i && st.run && st.phase == PH_T4 && st.ir_valid &&
		st.res_mem && !pcl_hit;

endmodule

/* File: logic/cfs_pkg.sv */
/*
 * shared constants and types of the fetch/sequencer core: instruction
 * layout, register map, stack geometry and the packed state record.
 * assumes a 16-bit instruction word and an 8-bit data memory space.
 */
package cfs_pkg;

	localparam int PC_W = 12;
	localparam int STACK_DEPTH = 6;
	localparam logic [2:0] SP_TOP = 3'h0;
	localparam logic [2:0] SP_FULL = 3'h6;
	localparam logic [11:0] RESET_VECTOR = 12'h000;
	localparam logic [11:0] INT_VECTOR = 12'h004;
	localparam logic [7:0] DM_PCL_ADDR = 8'h06;

	// wishbone byte addresses
	localparam logic [7:0] REG_PCL = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_IEN = 1;
	localparam logic CTRL_RUN_RST = 1'b1;
	localparam logic CTRL_IEN_RST = 1'b0;
	localparam int STAT_ACC_LO = 0;
	localparam int STAT_FLG_LO = 8;
	localparam int STAT_PEND = 12;
	localparam int STAT_RUN = 13;

	// instruction word fields
	localparam int INS_BRANCH = 15;
	localparam int INS_CALL = 14;
	localparam int INS_OP_HI = 14;
	localparam int INS_OP_LO = 10;
	localparam int INS_DEST = 8;

	localparam logic [3:0] DAA_NIB_MAX = 4'h9;
	localparam logic [7:0] DAA_BYTE_MAX = 8'h99;
	localparam logic [7:0] DAA_LO_ADJ = 8'h06;
	localparam logic [7:0] DAA_HI_ADJ = 8'h60;

	typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} cfs_phase_t;

	typedef enum logic [4:0] {
		OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_DAA, OP_AND, OP_OR,
		OP_XOR, OP_CPL, OP_RR, OP_RRC, OP_RL, OP_RLC, OP_INC, OP_DEC,
		OP_SZ, OP_SNZ, OP_SIZ, OP_SDZ, OP_LDA, OP_STA, OP_LDI, OP_RET,
		OP_INTERRUPT_RETURN
	} cfs_op_t;

	typedef struct packed {
		logic ov;
		logic z;
		logic ac;
		logic c;
	} cfs_flags_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic we;
	} cfs_dm_req_t;

	typedef struct packed {
		cfs_phase_t phase;
		logic [11:0] pc;
		logic [11:0] fetch_pc;
		logic [15:0] fetch_q;
		logic [15:0] ir;
		logic ir_valid;
		logic [7:0] acc;
		cfs_flags_t flg;
		logic [7:0] res;
		cfs_flags_t res_flg;
		logic res_acc;
		logic res_mem;
		logic skip;
		logic [5:0][11:0] stack;
		logic [2:0] sp;
		logic int_pend;
		logic int_en;
		logic int_ack;
		logic run;
		logic pcl_pend;
		logic [7:0] pcl_val;
		logic wb_ack;
		logic [31:0] wb_dat;
	} cfs_state_t;

	function automatic cfs_state_t cfs_reset_state();
		cfs_state_t s;
		s = '0;
		s.phase = PH_T1;
		s.pc = RESET_VECTOR;
		s.sp = SP_TOP;
		s.run = CTRL_RUN_RST;
		s.int_en = CTRL_IEN_RST;
		return s;
	endfunction

endpackage

/* File: testbench/cfs_core_monitor.sv */
/* port assertions for the sequencing core, bound into cfs_core.
 * assumes cfs_pkg and one clock domain with synchronous reset. */
`timescale 1ns/1ps
module cfs_core_monitor
	import cfs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [11:0] prog_addr_o,
	input wire cfs_dm_req_t dm_o,
	input wire logic int_ack_o,
	input wire cfs_phase_t instruction_phases_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	chk_phase_step: assert property (
		$changed(instruction_phases_o) && !$past(rst_i) |->
		2'(instruction_phases_o) == 2'($past(instruction_phases_o) + 2'h1))
		else $error("phase skipped or went back");
	chk_ce_freeze: assert property (
		!ce_i |=> $stable(instruction_phases_o))
		else $error("phase moved while clock enable low");
	chk_reset_pc: assert property (
		$past(rst_i) |-> prog_addr_o == RESET_VECTOR && instruction_phases_o == PH_T1)
		else $error("fetch after reset not at zero");
	chk_we_phase: assert property (
		dm_o.we |-> instruction_phases_o == PH_T4)
		else $error("data write outside last phase");
	chk_dm_hold: assert property (
		instruction_phases_o != PH_T1 && !$past(rst_i) |-> $stable(dm_o.addr))
		else $error("data address moved inside a cycle");
	chk_ack_next: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
		else $error("bus request not answered");
	chk_ack_drop: assert property (
		wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
	chk_iack_vec: assert property (
		int_ack_o |-> instruction_phases_o == PH_T1 && prog_addr_o == INT_VECTOR)
		else $error("interrupt entry not at vector");
	chk_iack_pulse: assert property (
		int_ack_o && ce_i |=> !int_ack_o)
		else $error("interrupt ack longer than one cycle");

	cover property (dm_o.we);
	cover property (int_ack_o);
	cover property (wb_ack_o);
endmodule

bind cfs_core cfs_core_monitor cfs_core_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
	.ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.prog_addr_o(prog_addr_o), .dm_o(dm_o), .int_ack_o(int_ack_o),
	.instruction_phases_o(instruction_phases_o));

/* File: testbench/cfs_mem_model.sv */
/* program and data memory facing the core.
 * assumes the bench preloads pmem and dmem before reset ends. */
`timescale 1ns/1ps
module cfs_mem_model
	import cfs_pkg::*;
(
	input wire logic clk_i,
	input wire logic [11:0] prog_addr_i,
	output logic [15:0] prog_data_o,
	input wire cfs_dm_req_t dm_i,
	output logic [7:0] dm_rdata_o
);
	logic [15:0] pmem [0:4095];
	logic [7:0] dmem [0:255];
	// combinational reads: the core's own sampling edge sets all timing
	assign prog_data_o = pmem[prog_addr_i];
	assign dm_rdata_o = dmem[dm_i.addr];
	always @(posedge clk_i) begin
		if (dm_i.we)
			dmem[dm_i.addr] <= dm_i.wdata;
	end
endmodule

/* File: testbench/test_cpu_fetch_sequencer_stack.sv */
/* self-checking bench: runs a short program, checks data writes and
 * register reads. assumes cfs_pkg, cfs_core and the memory model. */
`timescale 1ns/1ps
module test_cpu_fetch_sequencer_stack
	import cfs_pkg::*;
;
	logic clk_i = 0;
	logic rst_i = 1;
	logic ce_i = 0;
	logic cyc = 0;
	logic stb = 0;
	logic we = 0;
	logic irq = 0;
	logic [7:0] adr = 0;
	logic [31:0] dat = 0;
	logic [31:0] rdat;
	logic ack;
	logic iack;
	logic [11:0] pa;
	logic [15:0] pd;
	logic [7:0] dr;
	cfs_dm_req_t dm;
	cfs_phase_t ph;
	int fail_count = 0;
	int compares = 0;
	logic [15:0] exp_dm[$];
	logic [31:0] exp_wb[$];
	logic [15:0] prog [0:13];
	logic [7:0] a, m, m2, m3, m4, m5;

	always #25 clk_i = ~clk_i;

	cfs_core cfs_core_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .prog_addr_o(pa), .prog_data_i(pd), .dm_o(dm),
		.dm_rdata_i(dr), .irq_i(irq), .int_ack_o(iack), .instruction_phases_o(ph));
	cfs_mem_model cfs_mem_model_inst (.clk_i(clk_i), .prog_addr_i(pa),
		.prog_data_o(pd), .dm_i(dm), .dm_rdata_o(dr));

	function automatic logic [15:0] ins(input cfs_op_t op, input logic d, input logic [7:0] x);
		return {1'b0, op, 1'b0, d, x};
	endfunction
	function automatic logic [15:0] br(input logic c, input logic [11:0] t);
		return {1'b1, c, 2'b00, t};
	endfunction

	task cmp_dm(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t data write %h expected %h", $time, g, e);
		end
	endtask
	task cmp_wb(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t bus read %h expected %h", $time, g, e);
		end
	endtask

	task results;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// called just after a rising edge; holds the request until ack is sampled
	task wb(input logic [7:0] ad, input logic w, input logic [31:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= ad;
		dat <= d;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (ack === 1'b1)
				break;
		end
		if (ack !== 1'b1) begin
			fail_count++;
			results();
		end
		cyc <= 0;
		stb <= 0;
		we <= 0;
		@(posedge clk_i);
	endtask

	task drain;
		for (int i = 0; i < 400 && exp_dm.size() > 0; i++)
			@(posedge clk_i);
		if (exp_dm.size() > 0) begin
			fail_count++;
			results();
		end
	endtask

	always @(posedge clk_i) begin
		if (!rst_i && dm.we === 1'b1) begin
			if (exp_dm.size() == 0) begin
				fail_count++;
				$display("ERROR %0t unexpected data write", $time);
			end else
				cmp_dm({dm.addr, dm.wdata}, exp_dm.pop_front());
		end
		if (ack === 1'b1 && !we && exp_wb.size() > 0)
			cmp_wb(rdat, exp_wb.pop_front());
	end

	initial begin
		void'($urandom(82));
		a = $urandom;
		m = $urandom;
		m2 = $urandom;
		m3 = $urandom;
		m4 = $urandom;
		m5 = $urandom;
		prog = '{ins(OP_LDI, 0, a), ins(OP_STA, 1, 8'h20), ins(OP_XOR, 1, 8'h10),
			br(1, 12'h008), ins(OP_STA, 1, 8'h21), br(0, 12'h005), 16'h0, 16'h0,
			ins(OP_INC, 1, 8'h11), ins(OP_SZ, 0, 8'h12), ins(OP_STA, 1, 8'h22),
			ins(OP_RET, 0, 8'h00), ins(OP_STA, 1, 8'h23), br(0, 12'h00d)};
		for (int i = 0; i < 4096; i++)
			cfs_mem_model_inst.pmem[i] = (i < 14) ? prog[i] : 16'h0;
		for (int i = 0; i < 256; i++)
			cfs_mem_model_inst.dmem[i] = 8'h00;
		cfs_mem_model_inst.dmem[8'h10] = m;
		cfs_mem_model_inst.dmem[8'h11] = m2;
		cfs_mem_model_inst.dmem[8'h13] = m3;
		cfs_mem_model_inst.dmem[8'h14] = m4;
		cfs_mem_model_inst.dmem[8'h15] = m5;
		// alu block, reached later by a low-byte jump to 0x030
		cfs_mem_model_inst.pmem[12'h030] = ins(OP_LDI, 0, a);
		cfs_mem_model_inst.pmem[12'h031] = ins(OP_ADD, 1, 8'h13);
		cfs_mem_model_inst.pmem[12'h032] = ins(OP_SUB, 1, 8'h14);
		cfs_mem_model_inst.pmem[12'h033] = ins(OP_RLC, 1, 8'h15);
		cfs_mem_model_inst.pmem[12'h034] = br(0, 12'h034);
		// taken skip zeroes the accumulator, so the later stores write zero
		exp_dm = '{{8'h20, a}, {8'h10, a ^ m}, {8'h11, m2 + 8'h01}, {8'h21, 8'h00}};
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		repeat (2) @(posedge clk_i);
		ce_i <= 1;
		drain();
		exp_wb.push_back({30'h0, CTRL_IEN_RST, CTRL_RUN_RST});
		wb(REG_CTRL, 0, 32'h0);
		exp_wb.push_back(32'h0);
		wb(8'h0c, 0, 32'h0);
		exp_dm.push_back({8'h23, 8'h00});
		wb(REG_PCL, 1, 32'h0000000c);
		drain();
		exp_dm.push_back({8'h21, 8'h00});
		wb(REG_CTRL, 1, 32'h00000003);
		irq <= 1;
		for (int i = 0; i < 100 && iack !== 1'b1; i++)
			@(posedge clk_i);
		if (iack !== 1'b1) begin
			fail_count++;
			results();
		end
		irq <= 0;
		drain();
		// carry left by the subtract feeds the rotate: set means no borrow
		exp_dm.push_back({8'h13, 8'(a + m3)});
		exp_dm.push_back({8'h14, 8'(a - m4)});
		exp_dm.push_back({8'h15, m5[6:0], a >= m4});
		wb(REG_PCL, 1, 32'h00000030);
		drain();
		results();
	end
endmodule
